// File: rtl/oip_pkg.sv
package oip_pkg;
    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_MHZ = 50;
    localparam int DIS_LAT_NS = 5000;
    localparam int DIS_LAT_CYC = DIS_LAT_NS * CLK_MHZ / 1000;
    localparam int TRIP_US = 1000;
    localparam int TRIP_CYC = TRIP_US * CLK_MHZ;
    localparam int NCH = 4;
    localparam int NPIN = 7;
    localparam int PW = 16;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OUT_ON = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TYPE = 8'h10;
    localparam logic [7:0] ADDR_RATING = 8'h14;
    localparam logic [7:0] ADDR_PIN_SYNC = 8'h18;
    localparam logic [7:0] ADDR_LIMIT0 = 8'h20;
    localparam logic [7:0] ADDR_LIMIT3 = 8'h2c;

    // ************************************************************
    // Fields
    // ************************************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIS_NEG = 2;
    localparam int CTRL_FLT_NEG = 3;
    localparam int CTRL_LINE_LOW = 4;
    localparam int CMD_CLEAR = 0;
    localparam int ST_OVERLOAD = 0;
    localparam int ST_PLIM_LSB = 1;
    localparam int ST_TRIP_LSB = 5;
    localparam int ST_DIS_ACTIVE = 9;
    localparam int ST_FAULT = 10;
    localparam int ST_DIS_TRUE = 11;
    localparam logic [6:0] SYNC_ALLOWED = 7'h78;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_LIVE = 2'h1;
    localparam logic [1:0] MODE_LATCH = 2'h2;

    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [PW-1:0] RATING_RST = 16'h0190;
    localparam logic [PW+1:0] LOW_LINE_SUM_MAX = 18'h00258;
    localparam logic [PW-1:0] LIMIT_RST = 16'hffff;

    typedef enum logic [2:0] {
        TRIP_IDLE = 3'h1,
        TRIP_COUNT = 3'h2,
        TRIP_OFF = 3'h4
    } oip_trip_state_type;
endpackage

// File: rtl/oip_chan_limit.sv
`timescale 1ns/1ns
module oip_chan_limit
    import oip_pkg::*;
#(
    parameter int TRIP_CYCLES = TRIP_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PW-1:0] limit_w,
    input wire logic [PW-1:0] max_w,
    input wire logic [PW-1:0] power_w,
    input wire logic trip_type,
    input wire logic clear,
    output logic plim_flag,
    output logic tripped,
    output logic regulate
);
    typedef struct packed {
        oip_trip_state_type st;
        logic [31:0] cnt;
        logic flag;
        logic reg_on;
    } oip_cl_type;

    oip_cl_type s_r;
    oip_cl_type s_nxt;
    logic active;
    logic over;

    // ************************************************************
    // Power limit supervision
    // ************************************************************
    assign active = limit_w < max_w;
    assign over = active && (power_w > limit_w);

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.reg_on = 1'b0;
        case (s_r.st)
            TRIP_IDLE:
            begin
                s_nxt.cnt = 32'h0;
                s_nxt.flag = 1'b0;
                if (over && trip_type)
                begin
                    s_nxt.st = TRIP_COUNT;
                end
                else if (over)
                begin
                    s_nxt.flag = 1'b1;
                    s_nxt.reg_on = 1'b1;
                end
            end
            TRIP_COUNT:
            begin
                // Short excursions restart the timer, only a held overload trips
                if (!over)
                begin
                    s_nxt.st = TRIP_IDLE;
                end
                else if (s_r.cnt >= 32'(TRIP_CYCLES - 2))
                begin
                    s_nxt.st = TRIP_OFF;
                    s_nxt.flag = 1'b1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt + 32'h1;
                end
            end
            TRIP_OFF:
            begin
                if (clear && !over)
                begin
                    s_nxt.st = TRIP_IDLE;
                    s_nxt.flag = 1'b0;
                end
            end
            default:
            begin
                s_nxt.st = TRIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '{st: TRIP_IDLE, cnt: 32'h0, flag: 1'b0, reg_on: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign plim_flag = s_r.flag;
    assign tripped = (s_r.st == TRIP_OFF);
    assign regulate = s_r.reg_on;
endmodule

// File: rtl/oip_top.sv
`timescale 1ns/1ns
// Functional notes
// - Connector pin serves as remote disable input with selectable polarity.
// - Remote disable acts on all channels within 5 microseconds.
// - Disable mode latching, live or ignored, reloaded from non-volatile store.
// - Latching: true transition disables all outputs, stays after input drops.
// - Live: outputs off while input true, back on when it goes false.
// - Ignored mode: input has no effect on outputs.
// - Chained mainframes: any internal fault disables every mainframe via fault line.
// - Live mode: one protection clear clears chained fault for whole chain.
// - Output-state sync allowed only on the four upper pins.
// - Mainframe overload turns all outputs off until protection clear.
// - Mainframe overload flag set whenever overload event occurred.
// - Module power limit active only when limit below module maximum.
// - Trip modules: limit held ~1 ms turns output off, sets flag.
// - Regulating modules: held at limit with flag, recover automatically.
// - Low line input: limit sum above 600 W refused.
// - Positive polarity means high is true, negative means low is true.
// - Fault output on channel faults, remote disable, power fail, power limit.
// - Fault output latched until cause gone and protection cleared.
module oip_top
    import oip_pkg::*;
#(
    parameter int TRIP_CYCLES = TRIP_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dis_pin,
    output logic fault_pin,
    input wire logic [NCH-1:0] chan_fault,
    input wire logic power_fail,
    input wire logic [NCH*PW-1:0] chan_power_w,
    input wire logic [NCH*PW-1:0] chan_max_w,
    input wire logic [PW-1:0] total_power_w,
    input wire logic [1:0] nv_mode,
    output logic nv_wr,
    output logic [1:0] nv_wr_mode,
    output logic [NCH-1:0] chan_en,
    output logic [NCH-1:0] chan_regulate,
    output logic [NPIN-1:0] sync_pins
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic booted;
        logic [1:0] mode;
        logic dis_neg;
        logic flt_neg;
        logic line_low;
        logic [NCH-1:0] out_on;
        logic [NCH-1:0] trip_type;
        logic [PW-1:0] rating;
        logic [NPIN-1:0] pin_sync;
        logic [NCH*PW-1:0] limit;
        logic dis_s1;
        logic dis_s2;
        logic dis_prev;
        logic dis_latch;
        logic chain_flt;
        logic prot_flt;
        logic overload;
        logic clear;
        logic nv_wr;
        logic [1:0] nv_wr_mode;
        logic fault_pin;
        logic [NCH-1:0] chan_en;
        logic [NCH-1:0] chan_reg;
    } oip_state_type;

    oip_state_type s_r;
    oip_state_type s_nxt;
    logic [NCH-1:0] plim_flag;
    logic [NCH-1:0] tripped;
    logic [NCH-1:0] regulate;

    // ************************************************************
    // Per-channel power limit
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gen_ch
            oip_chan_limit #(
                .TRIP_CYCLES(TRIP_CYCLES)
            ) u_lim (
                .clk(clk),
                .rst(rst),
                .limit_w(s_r.limit[g*PW +: PW]),
                .max_w(chan_max_w[g*PW +: PW]),
                .power_w(chan_power_w[g*PW +: PW]),
                .trip_type(s_r.trip_type[g]),
                .clear(s_r.clear),
                .plim_flag(plim_flag[g]),
                .tripped(tripped[g]),
                .regulate(regulate[g])
            );
        end
    endgenerate

    // ************************************************************
    // Next state
    // ************************************************************
    logic dis_true;
    logic dis_rise;
    logic dis_active;
    logic prot_cause;
    logic over_total;
    logic setup;
    logic access;
    logic [31:0] rd;
    logic err;
    logic [PW+1:0] lim_sum;
    logic [1:0] lim_idx;
    logic [NPIN-1:0] nv;

    always_comb
    begin
        s_nxt = s_r;
        rd = 32'h0;
        err = 1'b0;
        lim_sum = '0;
        lim_idx = paddr[3:2];
        nv = '0;
        s_nxt.clear = 1'b0;
        s_nxt.nv_wr = 1'b0;

        // Mode comes back from non-volatile store once, after reset release
        if (!s_r.booted)
        begin
            s_nxt.booted = 1'b1;
            s_nxt.mode = (nv_mode == MODE_LIVE || nv_mode == MODE_LATCH) ? nv_mode
                : MODE_OFF;
        end

        // Two-flop synchroniser; only the second stage feeds logic
        s_nxt.dis_s1 = dis_pin;
        s_nxt.dis_s2 = s_r.dis_s1;
        dis_true = s_r.dis_s2 ^ s_r.dis_neg;
        s_nxt.dis_prev = dis_true;
        dis_rise = dis_true && !s_r.dis_prev;

        // APB: answer prepared in setup, presented in the access cycle
        setup = psel && !penable;
        access = psel && penable && s_r.pready;
        for (int i = 0; i < NCH; i++)
        begin
            if (ADDR_LIMIT0 + 8'(4 * i) != paddr)
            begin
                lim_sum = lim_sum + {2'b00, s_r.limit[i*PW +: PW]};
            end
        end
        lim_sum = lim_sum + {2'b00, pwdata[PW-1:0]};

        if (paddr == ADDR_CTRL)
        begin
            rd = {27'h0, s_r.line_low, s_r.flt_neg, s_r.dis_neg, s_r.mode};
            err = pwrite && (pwdata[1:0] == 2'h3);
        end
        else if (paddr == ADDR_OUT_ON)
        begin
            rd = {28'h0, s_r.out_on};
        end
        else if (paddr == ADDR_CMD)
        begin
            rd = 32'h0;
        end
        else if (paddr == ADDR_STATUS)
        begin
            rd = {20'h0, dis_true, s_r.fault_pin ^ s_r.flt_neg, s_r.dis_latch || s_r.chain_flt,
                tripped, plim_flag, s_r.overload};
            err = pwrite;
        end
        else if (paddr == ADDR_TYPE)
        begin
            rd = {28'h0, s_r.trip_type};
        end
        else if (paddr == ADDR_RATING)
        begin
            rd = {16'h0, s_r.rating};
        end
        else if (paddr == ADDR_PIN_SYNC)
        begin
            rd = {25'h0, s_r.pin_sync};
            err = pwrite && ((pwdata[NPIN-1:0] & ~SYNC_ALLOWED) != 7'h0);
        end
        else if (paddr >= ADDR_LIMIT0 && paddr <= ADDR_LIMIT3 && paddr[1:0] == 2'h0)
        begin
            rd = {16'h0, s_r.limit[lim_idx*PW +: PW]};
            err = pwrite && s_r.line_low && (lim_sum > LOW_LINE_SUM_MAX);
        end
        else
        begin
            err = 1'b1;
        end

        if (setup)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = pwrite ? 32'h0 : rd;
            s_nxt.pslverr = err;
        end
        else
        begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = 32'h0;
        end

        // Refused writes leave every register untouched
        if (access && pwrite && !s_r.pslverr)
        begin
            if (paddr == ADDR_CTRL)
            begin
                s_nxt.mode = pwdata[CTRL_MODE_LSB +: 2];
                s_nxt.dis_neg = pwdata[CTRL_DIS_NEG];
                s_nxt.flt_neg = pwdata[CTRL_FLT_NEG];
                s_nxt.line_low = pwdata[CTRL_LINE_LOW];
                s_nxt.nv_wr = 1'b1;
                s_nxt.nv_wr_mode = pwdata[CTRL_MODE_LSB +: 2];
            end
            else if (paddr == ADDR_OUT_ON)
            begin
                s_nxt.out_on = pwdata[NCH-1:0];
            end
            else if (paddr == ADDR_CMD)
            begin
                s_nxt.clear = pwdata[CMD_CLEAR];
            end
            else if (paddr == ADDR_TYPE)
            begin
                s_nxt.trip_type = pwdata[NCH-1:0];
            end
            else if (paddr == ADDR_RATING)
            begin
                s_nxt.rating = pwdata[PW-1:0];
            end
            else if (paddr == ADDR_PIN_SYNC)
            begin
                s_nxt.pin_sync = pwdata[NPIN-1:0];
            end
            else if (paddr >= ADDR_LIMIT0 && paddr <= ADDR_LIMIT3)
            begin
                s_nxt.limit[lim_idx*PW +: PW] = pwdata[PW-1:0];
            end
        end

        // ********************************************************
        // Remote disable
        // ********************************************************
        if (s_r.mode == MODE_LATCH)
        begin
            if (dis_rise)
            begin
                s_nxt.dis_latch = 1'b1;
            end
        end
        else
        begin
            // Leaving latching mode is the only way to release the latch
            s_nxt.dis_latch = 1'b0;
        end
        dis_active = s_r.dis_latch || (s_r.mode == MODE_LIVE && dis_true);

        // Chained fault is set by an edge, so a clear in live mode breaks the
        // loop through other mainframes even while their fault line holds us
        if (s_r.mode == MODE_OFF)
        begin
            s_nxt.chain_flt = 1'b0;
        end
        else if (dis_rise)
        begin
            s_nxt.chain_flt = 1'b1;
        end
        else if (s_r.clear && (s_r.mode == MODE_LIVE || !dis_true))
        begin
            s_nxt.chain_flt = 1'b0;
        end

        // ********************************************************
        // Mainframe overload and protection faults
        // ********************************************************
        over_total = total_power_w > s_r.rating;
        if (over_total)
        begin
            s_nxt.overload = 1'b1;
        end
        else if (s_r.clear)
        begin
            s_nxt.overload = 1'b0;
        end

        prot_cause = (|chan_fault) || power_fail || over_total || (|tripped);
        if (prot_cause)
        begin
            s_nxt.prot_flt = 1'b1;
        end
        else if (s_r.clear)
        begin
            s_nxt.prot_flt = 1'b0;
        end

        s_nxt.fault_pin = (s_r.prot_flt || s_r.chain_flt || s_r.overload) ^ s_r.flt_neg;

        // ********************************************************
        // Channel enables
        // ********************************************************
        for (int i = 0; i < NCH; i++)
        begin
            s_nxt.chan_en[i] = s_r.out_on[i] && !dis_active && !s_r.overload
                && !tripped[i];
        end
        s_nxt.chan_reg = regulate;
        nv = s_r.pin_sync & SYNC_ALLOWED;
        s_nxt.pin_sync = s_nxt.pin_sync & SYNC_ALLOWED;
        if (nv != s_r.pin_sync)
        begin
            s_nxt.pin_sync = nv;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.rating <= RATING_RST;
            s_r.limit <= {NCH{LIMIT_RST}};
            s_r.trip_type <= '1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign fault_pin = s_r.fault_pin;
    assign nv_wr = s_r.nv_wr;
    assign nv_wr_mode = s_r.nv_wr_mode;
    assign chan_en = s_r.chan_en;
    assign chan_regulate = s_r.chan_reg;
    assign sync_pins = s_r.pin_sync;
endmodule

// File: test/oip_far_src.sv
`timescale 1ns/1ns
// ********
// Far side: disable source and chained unit
// ********
module oip_far_src
#(
    parameter int LAG = 1
)
(
    input wire logic clk,
    input wire logic req,
    input wire logic neg,
    input wire logic chain,
    input wire logic fault_pin,
    input wire logic flt_neg,
    output logic dis_pin
);
    logic [7:0] lag_r = 8'h00;
    logic loop_true;
    // Chained unit passes our fault back into our disable input
    assign loop_true = chain && (fault_pin != flt_neg);
    always_ff @(posedge clk)
    begin
        lag_r <= {lag_r[6:0], req || loop_true};
    end
    // A switch to common reads low, so with neg set low is the true level
    assign dis_pin = lag_r[LAG-1] ^ neg;
endmodule

// File: test/oip_top_properties.sv
`timescale 1ns/1ns
// ********
// Protection supervisor checker
// ********
module oip_top_props
    import oip_pkg::*;
#(
    parameter int TRIP_CYCLES = TRIP_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input logic pready,
    input logic pslverr,
    input wire logic dis_pin,
    input logic fault_pin,
    input wire logic [NCH-1:0] chan_fault,
    input wire logic [PW-1:0] total_power_w,
    input wire logic [1:0] nv_mode,
    input logic nv_wr,
    input logic [1:0] nv_wr_mode,
    input logic [NCH-1:0] chan_en,
    input logic [NPIN-1:0] sync_pins
);
    logic acc_wr;
    logic setup;
    logic first_r;
    logic dis_neg_r;
    logic flt_neg_r;
    logic [1:0] mode_r;
    logic [3:0] quiet_r;
    logic [PW-1:0] rating_r;
    logic dis_true;
    logic flt_true;
    logic quiet;
    assign acc_wr = psel && penable && pready && pwrite && !pslverr;
    assign setup = psel && !penable;
    assign dis_true = dis_pin ^ dis_neg_r;
    assign flt_true = fault_pin ^ flt_neg_r;
    // Any write may lift a shutdown, so hold checks off for a while after one
    assign quiet = quiet_r == 4'hf;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            first_r <= 1'h1;
            dis_neg_r <= 1'h0;
            flt_neg_r <= 1'h0;
            mode_r <= MODE_OFF;
            quiet_r <= 4'h0;
            rating_r <= RATING_RST;
        end
        else
        begin
            first_r <= 1'h0;
            quiet_r <= acc_wr ? 4'h0 : (quiet ? quiet_r : quiet_r + 4'h1);
            if (first_r)
                mode_r <= (nv_mode == 2'h3) ? MODE_OFF : nv_mode;
            if (acc_wr && paddr == ADDR_CTRL)
            begin
                mode_r <= pwdata[1:0];
                dis_neg_r <= pwdata[CTRL_DIS_NEG];
                flt_neg_r <= pwdata[CTRL_FLT_NEG];
            end
            if (acc_wr && paddr == ADDR_RATING)
                rating_r <= pwdata[PW-1:0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_live_rise;
        quiet && mode_r == MODE_LIVE && $rose(dis_true);
    endsequence
    sequence s_off_change;
        quiet && mode_r == MODE_OFF && $changed(dis_pin);
    endsequence
    property p_apb_answer;
        setup |=> pready ##1 !pready;
    endproperty
    property p_sync_refuse;
        setup && pwrite && paddr == ADDR_PIN_SYNC && pwdata[2:0] != 3'h0
            |=> pslverr ##1 $stable(sync_pins);
    endproperty
    property p_nv_store;
        acc_wr && paddr == ADDR_CTRL |-> ##[1:3] (nv_wr && nv_wr_mode == mode_r);
    endproperty
    property p_live_off;
        s_live_rise |-> ##[1:250] chan_en == 4'h0;
    endproperty
    property p_latch_hold;
        quiet && mode_r == MODE_LATCH && chan_en == 4'h0 |=> chan_en == 4'h0;
    endproperty
    property p_off_ignore;
        s_off_change |=> $stable(chan_en)[*6];
    endproperty
    property p_fault_raise;
        quiet && $rose(|chan_fault) |-> ##[1:8] flt_true;
    endproperty
    property p_fault_hold;
        quiet && flt_true |=> flt_true;
    endproperty
    property p_overload;
        quiet && total_power_w > rating_r |-> ##[1:8] chan_en == 4'h0;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
    a_sync_refuse: assert property (p_sync_refuse) else $error("sync pin taken");
    a_nv_store: assert property (p_nv_store) else $error("mode not stored");
    a_live_off: assert property (p_live_off) else $error("live disable late");
    a_latch_hold: assert property (p_latch_hold) else $error("latch released");
    a_off_ignore: assert property (p_off_ignore) else $error("pin not ignored");
    a_fault_raise: assert property (p_fault_raise) else $error("fault not raised");
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
    a_overload: assert property (p_overload) else $error("overload ignored");
endmodule
bind oip_top oip_top_props #(.TRIP_CYCLES(TRIP_CYCLES)) i_props (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .dis_pin(dis_pin), .fault_pin(fault_pin),
    .chan_fault(chan_fault), .total_power_w(total_power_w), .nv_mode(nv_mode),
    .nv_wr(nv_wr), .nv_wr_mode(nv_wr_mode), .chan_en(chan_en), .sync_pins(sync_pins));

// File: test/testbench.sv
`timescale 1ns/1ns
// ********
// Protection supervisor testbench
// ********
module testbench
    import oip_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dis_pin;
    logic fault_pin;
    logic [NCH-1:0] chan_fault = 4'h0;
    logic [NCH*PW-1:0] chan_power_w = 64'h0;
    logic [NCH*PW-1:0] chan_max_w = 64'h0;
    logic [PW-1:0] total_power_w = 16'h0;
    logic [NCH-1:0] chan_en;
    logic [NCH-1:0] chan_regulate;
    logic [NPIN-1:0] sync_pins;
    logic req = 1'h0;
    logic neg = 1'h0;
    logic chain = 1'h0;
    logic [15:0] lim0, lim3;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    // Short trip count keeps the run brief
    oip_top #(.TRIP_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dis_pin(dis_pin), .fault_pin(fault_pin), .chan_fault(chan_fault),
        .power_fail(1'h0), .chan_power_w(chan_power_w), .chan_max_w(chan_max_w),
        .total_power_w(total_power_w), .nv_mode(2'h1), .nv_wr(), .nv_wr_mode(),
        .chan_en(chan_en), .chan_regulate(chan_regulate), .sync_pins(sync_pins));
    oip_far_src #(.LAG(3)) i_far (.clk(clk), .req(req), .neg(neg), .chain(chain),
        .fault_pin(fault_pin), .flt_neg(1'h0), .dis_pin(dis_pin));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic err);
        exp_q.push_back({err, m, d});
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'h1, a, d, 32'h0, err);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'h0, a, d, m, 1'h0);
    endtask
    task automatic settle();
        repeat (16) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, want);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'h1)
        begin
            e = exp_q.pop_front();
            comparisons++;
            if (pslverr !== e[64] || (prdata & e[63:32]) !== (e[31:0] & e[63:32]))
            begin
                failures++;
                $display("ERROR %0t apb answer %h err %b", $time, prdata, pslverr);
            end
        end
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            failures++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(54370));
        lim0 = 16'(16'h64 + $urandom % 100);
        lim3 = 16'(LOW_LINE_SUM_MAX) - 16'h00e4 - lim0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(ADDR_CTRL, 32'h1, 32'h1f);
        rd(ADDR_RATING, 32'(RATING_RST), 32'hffffffff);
        rd(ADDR_LIMIT0, 32'(LIMIT_RST), 32'hffffffff);
        rd(ADDR_TYPE, 32'hf, 32'hffffffff);
        apb(1'h0, 8'h40, 32'h0, 32'h0, 1'h1);
        wr(ADDR_STATUS, 32'h1, 1'h1);
        wr(ADDR_OUT_ON, 32'hf, 1'h0);
        req <= 1'h1;
        settle();
        chk(chan_en, 32'h0);
        rd(ADDR_STATUS, 32'he00, 32'he00);
        req <= 1'h0;
        settle();
        chk(chan_en, 32'hf);
        chk(fault_pin, 32'h1);
        wr(ADDR_CMD, 32'h1, 1'h0);
        settle();
        chk(fault_pin, 32'h0);
        // Polarity swaps only in off mode, else the swap itself is an edge
        wr(ADDR_CTRL, 32'h0, 1'h0);
        neg <= 1'h1;
        chain <= 1'h1;
        settle();
        wr(ADDR_CTRL, 32'h5, 1'h0);
        settle();
        chk(chan_en, 32'hf);
        req <= 1'h1;
        settle();
        req <= 1'h0;
        settle();
        chk(chan_en, 32'h0);
        wr(ADDR_CMD, 32'h1, 1'h0);
        settle();
        chk(chan_en, 32'hf);
        wr(ADDR_CTRL, 32'h0, 1'h0);
        neg <= 1'h0;
        chain <= 1'h0;
        settle();
        wr(ADDR_CTRL, 32'h2, 1'h0);
        req <= 1'h1;
        settle();
        req <= 1'h0;
        settle();
        chk(chan_en, 32'h0);
        wr(ADDR_CTRL, 32'h0, 1'h0);
        wr(ADDR_CTRL, 32'h2, 1'h0);
        settle();
        chk(chan_en, 32'hf);
        wr(ADDR_CTRL, 32'h0, 1'h0);
        settle();
        req <= 1'h1;
        settle();
        chk(chan_en, 32'hf);
        wr(ADDR_CTRL, 32'h3, 1'h1);
        total_power_w <= RATING_RST + 16'h1;
        settle();
        chk(chan_en, 32'h0);
        rd(ADDR_STATUS, 32'h1, 32'h1);
        wr(ADDR_CMD, 32'h1, 1'h0);
        req <= 1'h0;
        settle();
        chk(chan_en, 32'h0);
        total_power_w <= 16'h0100;
        wr(ADDR_CMD, 32'h1, 1'h0);
        settle();
        chk(chan_en, 32'hf);
        chan_max_w <= {16'h0100, 16'h0100, 16'h0100, 16'h1000};
        chan_power_w <= {32'h0, 16'h0200, lim0 + 16'h1};
        wr(ADDR_LIMIT0 + 8'h04, 32'h100, 1'h0);
        wr(ADDR_LIMIT0, {16'h0, lim0}, 1'h0);
        repeat (10) @(posedge clk);
        chk(chan_en, 32'hf);
        repeat (20) @(posedge clk);
        chk(chan_en, 32'he);
        rd(ADDR_STATUS, 32'h22, 32'h3e);
        wr(ADDR_TYPE, 32'hd, 1'h0);
        wr(ADDR_LIMIT0 + 8'h04, 32'h80, 1'h0);
        settle();
        chk({chan_regulate, chan_en}, 32'h2e);
        chan_power_w <= {32'h0, 16'h0070, 16'h0};
        wr(ADDR_CMD, 32'h1, 1'h0);
        settle();
        chk({chan_regulate, chan_en}, 32'h0f);
        wr(ADDR_LIMIT0 + 8'h08, 32'h64, 1'h0);
        wr(ADDR_CTRL, 32'h10, 1'h0);
        wr(ADDR_LIMIT3, {16'h0, lim3 + 16'h1}, 1'h1);
        wr(ADDR_LIMIT3, {16'h0, lim3}, 1'h0);
        rd(ADDR_LIMIT3, {16'h0, lim3}, 32'hffff);
        wr(ADDR_PIN_SYNC, 32'h78, 1'h0);
        wr(ADDR_PIN_SYNC, 32'h01, 1'h1);
        chk(sync_pins, 32'h78);
        settle();
        chan_fault <= 4'(4'h1 << ($urandom % 4));
        settle();
        chk(fault_pin, 32'h1);
        chan_fault <= 4'h0;
        settle();
        chk(fault_pin, 32'h1);
        wr(ADDR_CMD, 32'h1, 1'h0);
        settle();
        chk(fault_pin, 32'h0);
        conclude();
    end
endmodule
